// ===== hw/fpe_ctrl.sv
/*
 * fpe_ctrl: flash program/erase control between the CPU core's external
 * data moves and a byte-wide flash macro, with a scratchpad page.
 * Assumes the core holds its pipeline while o_cpu_stall is high and the
 * flash macro programs/erases on a one-cycle o_flash.busy start edge.
 */
`timescale 1ns/1ns
`default_nettype none
module fpe_ctrl
	import fpe_pkg::*;
#(
	parameter int PROG_CNT  = PROG_CYCLES,
	parameter int ERASE_CNT = ERASE_CYCLES
) (
	input  wire logic          i_mclk,
	input  wire logic          i_rst_n,
	input  wire logic          i_por,
	input  wire logic [3:0]    i_reg_addr,
	input  wire logic [7:0]    i_reg_wdata,
	input  wire logic          i_reg_wr,
	input  wire logic          i_reg_rd,
	output logic      [7:0]    o_reg_rdata,
	input  wire fpe_xdata_t    i_xdata,
	input  wire logic          i_fetch,
	input  wire logic [15:0]   i_fetch_addr,
	input  wire logic [7:0]    i_flash_rdata,
	output fpe_xdata_t         o_external_ram_space,
	output fpe_flash_op_t      o_flash,
	output logic               o_fetch_scratch,
	output logic               o_fetch_fault,
	output logic               o_cpu_stall,
	output logic               o_flash_err_rst
);
	typedef struct packed {
		logic          wr_en;
		logic          er_en;
		logic          scr_sel;
		fpe_key_t      key;
		logic [7:0]    mon;
		logic          err_rst;
		logic [7:0]    rdata;
		fpe_xdata_t    external_ram_space;
		fpe_flash_op_t op;
		logic          start;
		logic          scr_fetch;
		logic          fetch_fault;
		logic          stall;
	} fpe_state_t;

	fpe_state_t s_q, s_d;
	logic [1:0] rst_sync_q;
	logic       flash_err_q;
	logic       flash_err_d;
	logic       srst_n;
	logic       tmr_busy;
	logic       tmr_done;
	logic       attempt;
	logic       reaches_flash;
	logic       mon_ok;

	function automatic logic in_scratch(input logic [15:0] a);
		return a <= SCRATCH_LAST;
	endfunction : in_scratch

	assign srst_n = rst_sync_q[1];

	fpe_op_timer #(
		.PROG_CNT  (PROG_CNT),
		.ERASE_CNT (ERASE_CNT)
	) u_timer (
		.i_clk   (i_mclk),
		.i_rst_n (srst_n),
		.i_start (s_q.start),
		.i_erase (s_q.op.erase),
		.o_busy  (tmr_busy),
		.o_done  (tmr_done)
	);

	always_comb begin
		// short-form moves only reach flash up to the boundary
		reaches_flash = !(i_xdata.short_form && i_xdata.addr > SHORT_ADDR_MAX);
		attempt = i_xdata.wr && s_q.wr_en && reaches_flash;
		mon_ok  = s_q.mon[BIT_MON_EN] && s_q.mon[BIT_MON_RST_EN];
	end

	always_comb begin
		s_d          = s_q;
		flash_err_d  = flash_err_q;
		s_d.start    = 1'b0;
		s_d.rdata    = 8'h00;
		s_d.external_ram_space     = '0;
		s_d.err_rst  = 1'b0;

		if (i_reg_wr) begin
			unique case (i_reg_addr)
				REG_STORE_CTRL: begin
					// only software changes these enables
					s_d.wr_en   = i_reg_wdata[BIT_WRITE_EN];
					s_d.er_en   = i_reg_wdata[BIT_ERASE_EN];
					s_d.scr_sel = i_reg_wdata[BIT_SCRATCH_SEL];
				end
				REG_UNLOCK_KEY: begin
					unique case (s_q.key)
						KEY_LOCKED: s_d.key = (i_reg_wdata == UNLOCK_CODE_1)
							? KEY_HALF : KEY_DEAD;
						KEY_HALF:   s_d.key = (i_reg_wdata == UNLOCK_CODE_2)
							? KEY_OPEN : KEY_DEAD;
						KEY_OPEN:   s_d.key = KEY_DEAD;
						KEY_DEAD:   s_d.key = KEY_DEAD;
					endcase
				end
				REG_SUPPLY_MON: s_d.mon = i_reg_wdata & SUPPLY_MON_RST;
				REG_RESET_CAUSE: flash_err_d = 1'b0;
				default: ;
			endcase
		end
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				REG_STORE_CTRL: s_d.rdata = {5'h00, s_q.scr_sel, s_q.er_en,
					s_q.wr_en};
				REG_UNLOCK_KEY: s_d.rdata = {6'h00, s_q.key};
				REG_RESET_CAUSE: s_d.rdata = {7'h00, flash_err_q};
				REG_SUPPLY_MON: s_d.rdata = s_q.mon;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// reads always go to external ram writes unless redirected
		if (i_xdata.rd || (i_xdata.wr && !attempt))
			s_d.external_ram_space = i_xdata;

		if (attempt && !s_q.op.busy) begin
			if (!mon_ok) begin
				s_d.err_rst   = 1'b1;
				flash_err_d   = 1'b1;
			end else if (s_q.key == KEY_OPEN) begin
				s_d.start      = 1'b1;
				s_d.op.busy    = 1'b1;
				s_d.op.erase   = s_q.er_en;
				s_d.op.scratch = s_q.scr_sel && in_scratch(i_xdata.addr);
				s_d.op.addr    = s_q.er_en
					? {i_xdata.addr[15:PAGE_BITS], {PAGE_BITS{1'b0}}}
					: i_xdata.addr;
				// a write can only pull bits low
				s_d.op.data    = s_q.er_en ? ERASED_BYTE
					: (i_xdata.data & i_flash_rdata);
				s_d.key        = KEY_LOCKED;
			end else begin
				s_d.key = KEY_DEAD;
			end
		end
		if (tmr_done)
			s_d.op.busy = 1'b0;
		s_d.stall = s_d.op.busy;

		// fetches below the boundary never see the scratchpad
		s_d.scr_fetch   = 1'b0;
		s_d.fetch_fault = i_fetch && s_q.scr_sel && in_scratch(i_fetch_addr);
	end

	// sync stages and error flag live outside the state struct because
	// each has a reset of its own
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	always_ff @(posedge i_mclk or negedge srst_n) begin
		if (!srst_n) begin
			s_q.wr_en       <= 1'b0;
			s_q.er_en       <= 1'b0;
			s_q.scr_sel     <= 1'b0;
			s_q.key         <= KEY_LOCKED;
			s_q.mon         <= SUPPLY_MON_RST;
			s_q.err_rst     <= 1'b0;
			s_q.rdata       <= 8'h00;
			s_q.external_ram_space        <= '0;
			s_q.op          <= '0;
			s_q.start       <= 1'b0;
			s_q.scr_fetch   <= 1'b0;
			s_q.fetch_fault <= 1'b0;
			s_q.stall       <= 1'b0;
		end else begin
			s_q.wr_en       <= s_d.wr_en;
			s_q.er_en       <= s_d.er_en;
			s_q.scr_sel     <= s_d.scr_sel;
			s_q.key         <= s_d.key;
			s_q.mon         <= s_d.mon;
			s_q.err_rst     <= s_d.err_rst;
			s_q.rdata       <= s_d.rdata;
			s_q.external_ram_space        <= s_d.external_ram_space;
			s_q.op          <= s_d.op;
			s_q.start       <= s_d.start;
			s_q.scr_fetch   <= s_d.scr_fetch;
			s_q.fetch_fault <= s_d.fetch_fault;
			s_q.stall       <= s_d.stall;
		end
	end

	// the error flag must outlive the reset it causes, so only power-on or a
	// reset_cause_register write clears it; the system reset leaves it standing
	always_ff @(posedge i_mclk) begin
		if (i_por)
			flash_err_q <= 1'b0;
		else
			flash_err_q <= flash_err_d;
	end

	assign o_reg_rdata     = s_q.rdata;
	assign o_external_ram_space          = s_q.external_ram_space;
	assign o_flash         = s_q.op;
	assign o_fetch_scratch = s_q.scr_fetch;
	assign o_fetch_fault   = s_q.fetch_fault;
	assign o_cpu_stall     = s_q.stall;
	assign o_flash_err_rst = s_q.err_rst;

	default clocking assert_cb @(posedge i_mclk);
	endclocking
	default disable iff (!srst_n);

	a_unlock_order: assert property (
		i_reg_wr && i_reg_addr == REG_UNLOCK_KEY && s_q.key == KEY_LOCKED
		&& i_reg_wdata != UNLOCK_CODE_1 |=> s_q.key == KEY_DEAD)
		else $error("wrong first code did not lock out");
	a_unlock_pair: assert property (
		i_reg_wr && i_reg_addr == REG_UNLOCK_KEY && s_q.key == KEY_HALF
		&& i_reg_wdata == UNLOCK_CODE_2 && !attempt
		|=> s_q.key == KEY_OPEN)
		else $error("correct code pair did not unlock");
	a_dead_sticky: assert property (
		s_q.key == KEY_DEAD |=> s_q.key == KEY_DEAD)
		else $error("lockout left before reset");
	a_early_attempt: assert property (
		attempt && mon_ok && !s_q.op.busy && s_q.key != KEY_OPEN
		|=> s_q.key == KEY_DEAD && !s_q.start)
		else $error("early flash access not locked out");
	a_relock: assert property (
		s_q.start |-> s_q.key == KEY_LOCKED)
		else $error("key still open after operation start");
	a_wen_sticky: assert property (
		!(i_reg_wr && i_reg_addr == REG_STORE_CTRL) |=> $stable(s_q.wr_en))
		else $error("write enable changed without software");
	a_mon_reset: assert property (
		attempt && !mon_ok && !s_q.op.busy && !i_por
		|=> o_flash_err_rst && flash_err_q && !s_q.start)
		else $error("supply interlock missed");
	a_prog_clear: assert property (
		s_q.start && !s_q.op.erase
		|-> (s_q.op.data & ~$past(i_flash_rdata)) == 8'h00)
		else $error("programming set a bit");
	a_erase_page: assert property (
		s_q.start && s_q.op.erase
		|-> s_q.op.addr[PAGE_BITS-1:0] == '0 && s_q.op.data == ERASED_BYTE)
		else $error("erase not page aligned");
	a_op_kind: assert property (
		s_q.start |-> s_q.op.erase == $past(s_q.er_en))
		else $error("operation kind differs from erase enable");
	a_op_target: assert property (
		s_q.start && !s_q.op.erase |-> s_q.op.addr == $past(i_xdata.addr))
		else $error("program address differs from the move");
	a_stall_cover: assert property (
		s_q.start |=> o_cpu_stall && tmr_busy)
		else $error("cpu not stalled during operation");
	a_stall_hold: assert property (
		tmr_busy |-> o_cpu_stall)
		else $error("cpu released while timer runs");
	a_short_form: assert property (
		i_xdata.short_form && i_xdata.addr > SHORT_ADDR_MAX && !s_q.op.busy
		|=> !s_q.start)
		else $error("short move reached flash");
	a_reads_external_ram_space: assert property (
		i_xdata.rd |=> o_external_ram_space.rd && !s_q.start)
		else $error("external read left ram");
	a_scratch_map: assert property (
		s_q.start |-> s_q.op.scratch
		== ($past(s_q.scr_sel) && $past(i_xdata.addr) <= SCRATCH_LAST))
		else $error("scratchpad mapping wrong");
	a_fetch_fault: assert property (
		i_fetch && s_q.scr_sel && in_scratch(i_fetch_addr)
		|=> o_fetch_fault && !o_fetch_scratch)
		else $error("scratchpad fetch was served");
	a_wen_clear: assert property (
		i_xdata.wr && !s_q.wr_en
		&& !(i_reg_wr && i_reg_addr == REG_UNLOCK_KEY)
		|=> o_external_ram_space.wr && !s_q.start && $stable(s_q.key))
		else $error("write without enable left ram");
endmodule : fpe_ctrl
`default_nettype wire

// ===== hw/fpe_pkg.sv
/*
 * fpe_pkg: constants and carrier types for the flash program/erase control.
 * Assumes a byte-wide CPU core and a flash macro with a byte port.
 */
package fpe_pkg;

	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          PAGE_BITS       = 10;   // 1024-byte pages
	localparam logic [7:0]  UNLOCK_CODE_1   = 8'ha5;
	localparam logic [7:0]  UNLOCK_CODE_2   = 8'hf1;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [15:0] SHORT_ADDR_MAX  = 16'h00ff;
	localparam logic [15:0] SCRATCH_LAST    = 16'h03ff;

	// register map on the plain port (word indices)
	localparam logic [3:0]  REG_STORE_CTRL  = 4'h0; // program_store_control
	localparam logic [3:0]  REG_UNLOCK_KEY  = 4'h1; // flash_unlock_key_register
	localparam logic [3:0]  REG_RESET_CAUSE = 4'h2; // reset_cause_register
	localparam logic [3:0]  REG_SUPPLY_MON  = 4'h3; // supply monitor enables

	// program_store_control fields
	localparam int          BIT_WRITE_EN    = 0;
	localparam int          BIT_ERASE_EN    = 1;
	localparam int          BIT_SCRATCH_SEL = 2;
	// supply monitor fields
	localparam int          BIT_MON_EN      = 0;
	localparam int          BIT_MON_RST_EN  = 1;
	localparam logic [7:0]  SUPPLY_MON_RST  = 8'h03;
	// reset cause field
	localparam int          BIT_FLASH_ERR   = 0;

	// operation times
	localparam int          CLK_MHZ         = 250;
	localparam int          PROG_TIME_US    = 20;
	localparam int          ERASE_TIME_MS   = 20;
	localparam int          PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
	localparam int          ERASE_CYCLES    = ERASE_TIME_MS * 1000 * CLK_MHZ;

	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF   = 2'b01,
		KEY_OPEN   = 2'b11,
		KEY_DEAD   = 2'b10
	} fpe_key_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic              short_form;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpe_xdata_t;

	typedef struct packed {
		logic              busy;
		logic              erase;
		logic              scratch;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpe_flash_op_t;

endpackage : fpe_pkg

// ===== hw/fpe_op_timer.sv
/*
 * fpe_op_timer: self-timed duration counter for one flash operation.
 * Assumes start is a one-cycle pulse given only while idle.
 */
`timescale 1ns/1ns
`default_nettype none
module fpe_op_timer
	import fpe_pkg::*;
#(
	parameter int PROG_CNT  = PROG_CYCLES,
	parameter int ERASE_CNT = ERASE_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_start,
	input  wire logic i_erase,
	output logic      o_busy,
	output logic      o_done
);
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] cnt;
	} fpe_tmr_t;

	fpe_tmr_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (s_q.busy) begin
			if (s_q.cnt == 32'h1) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 32'h1;
			end
		end else if (i_start) begin
			s_d.busy = 1'b1;
			s_d.cnt  = i_erase ? 32'(ERASE_CNT) : 32'(PROG_CNT);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_busy = s_q.busy;
	assign o_done = s_q.done;
endmodule : fpe_op_timer
`default_nettype wire

// ===== verif/fpe_flash_model.sv
/*
 * fpe_flash_model: behavioural byte-wide flash macro behind fpe_ctrl.
 * Assumes operations start on a rising o_flash.busy edge, 4 kB is enough.
 */
`timescale 1ns/1ns
`default_nettype none
module fpe_flash_model
	import fpe_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic [15:0]   i_addr,
	input  wire fpe_flash_op_t i_op,
	output logic      [7:0]    o_rdata
);
	logic [7:0] mem [0:4095];
	logic       busy_q = 1'b0;

	// a non-erased pattern makes the and-with-current-byte visible
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'hf0;
	assign o_rdata = mem[i_addr[11:0]];

	always @(posedge i_clk) begin
		busy_q <= i_op.busy;
		if (i_op.busy && !busy_q) begin
			if (i_op.erase)
				for (int i = 0; i < 1024; i++)
					mem[{i_op.addr[11:10], i[9:0]}] = ERASED_BYTE;
			else
				mem[i_op.addr[11:0]] = i_op.data;
		end
	end
endmodule : fpe_flash_model
`default_nettype wire

// ===== verif/tb_flash_program_erase_control.sv
/*
 * tb_flash_program_erase_control: directed scenarios for fpe_ctrl.
 * Assumes short sim counts (4 and 8) and the flash model as macro.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_control;
	import fpe_pkg::*;
	logic          mclk, rst_n, por, reg_wr, reg_rd, fetch;
	logic [3:0]    reg_addr;
	logic [7:0]    reg_wdata, frd, rdata, d;
	logic [15:0]   fetch_addr;
	fpe_xdata_t    xd, external_ram_space;
	fpe_flash_op_t fop;
	logic          fscr, ffault, stall, erst;
	int            fails = 0, checked = 0;

	fpe_ctrl #(.PROG_CNT(4), .ERASE_CNT(8)) dut (.i_mclk(mclk),
		.i_rst_n(rst_n), .i_por(por), .i_reg_addr(reg_addr),
		.i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.o_reg_rdata(rdata), .i_xdata(xd), .i_fetch(fetch),
		.i_fetch_addr(fetch_addr), .i_flash_rdata(frd), .o_external_ram_space(external_ram_space),
		.o_flash(fop), .o_fetch_scratch(fscr), .o_fetch_fault(ffault),
		.o_cpu_stall(stall), .o_flash_err_rst(erst));
	fpe_flash_model flash (.i_clk(mclk), .i_addr(xd.addr), .i_op(fop),
		.o_rdata(frd));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task give_verdict;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task do_reset;
		rst_n <= 1'b0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		por   <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : do_reset
	task wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask : wreg
	task rreg(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task unlock;
		wreg(REG_UNLOCK_KEY, UNLOCK_CODE_1);
		wreg(REG_UNLOCK_KEY, UNLOCK_CODE_2);
	endtask : unlock
	// move is taken at the next edge; outputs sampled just after it
	task xmove(input logic w, r, s, input logic [15:0] a,
		input logic [7:0] v);
		@(posedge mclk);
		xd <= '{wr: w, rd: r, short_form: s, addr: a, data: v};
		@(posedge mclk);
		xd <= '0;
		#1;
	endtask : xmove
	task wait_idle;
		int n;
		n = 0;
		while (fop.busy !== 1'b0 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		#1 chk({fop.busy, stall}, 16'h0);
	endtask : wait_idle

	task t_reset;
		rreg(REG_SUPPLY_MON);
		chk(d, SUPPLY_MON_RST);
		rreg(REG_UNLOCK_KEY);
		chk(d, 16'h0);
	endtask : t_reset
	task t_prog;
		wreg(REG_STORE_CTRL, 8'h01);
		wreg(REG_UNLOCK_KEY, UNLOCK_CODE_1);
		repeat (50) @(posedge mclk);
		wreg(REG_UNLOCK_KEY, UNLOCK_CODE_2);
		rreg(REG_UNLOCK_KEY);
		chk(d, 16'h3);
		xmove(1'b1, 1'b0, 1'b0, 16'h1234, 8'h3c);
		chk({fop.busy, fop.erase, stall}, 16'h5);
		chk(fop.addr, 16'h1234);
		chk(fop.data, 16'h30);
		wait_idle;
		xd.addr <= 16'h1234;
		#1 chk(frd, 16'h30);
		rreg(REG_UNLOCK_KEY);
		chk(d, 16'h0);
		rreg(REG_STORE_CTRL);
		chk(d, 16'h1);
		wreg(REG_STORE_CTRL, 8'h00);
	endtask : t_prog
	task t_erase;
		wreg(REG_STORE_CTRL, 8'h03);
		unlock;
		xmove(1'b1, 1'b0, 1'b0, 16'h1655, 8'h00);
		chk({fop.busy, fop.erase, stall}, 16'h7);
		chk(fop.addr, 16'h1400);
		chk(fop.data, ERASED_BYTE);
		wait_idle;
		xd.addr <= 16'h17ff;
		#1 chk(frd, 16'hff);
	endtask : t_erase
	task t_external_ram_space;
		wreg(REG_STORE_CTRL, 8'h00);
		xmove(1'b1, 1'b0, 1'b0, 16'h2000, 8'h5a);
		chk({external_ram_space.wr, fop.busy}, 16'h2);
		chk(external_ram_space.data, 16'h5a);
		xmove(1'b0, 1'b1, 1'b0, 16'h2001, 8'h00);
		chk({external_ram_space.rd, fop.busy}, 16'h2);
	endtask : t_external_ram_space
	task t_fetch;
		wreg(REG_STORE_CTRL, 8'h04);
		@(posedge mclk);
		fetch      <= 1'b1;
		fetch_addr <= SCRATCH_LAST;
		@(posedge mclk);
		fetch      <= 1'b0;
		#1 chk({ffault, fscr}, 16'h2);
	endtask : t_fetch
	task t_monitor;
		wreg(REG_SUPPLY_MON, 8'h01);
		wreg(REG_STORE_CTRL, 8'h01);
		unlock;
		xmove(1'b1, 1'b0, 1'b0, 16'h1300, 8'h00);
		chk({erst, fop.busy}, 16'h2);
		rreg(REG_RESET_CAUSE);
		chk(d[0], 16'h1);
	endtask : t_monitor
	task t_short;
		wreg(REG_STORE_CTRL, 8'h05);
		unlock;
		xmove(1'b1, 1'b0, 1'b1, SHORT_ADDR_MAX, 8'h0f);
		chk(fop.busy, 16'h1);
		chk(fop.scratch, 16'h1);
		wait_idle;
		unlock;
		xmove(1'b1, 1'b0, 1'b1, 16'h0100, 8'h0f);
		chk(fop.busy, 16'h0);
	endtask : t_short
	task t_wrong;
		wreg(REG_UNLOCK_KEY, UNLOCK_CODE_2);
		rreg(REG_UNLOCK_KEY);
		chk(d, 16'h2);
		wreg(REG_STORE_CTRL, 8'h01);
		unlock;
		xmove(1'b1, 1'b0, 1'b0, 16'h1100, 8'h00);
		chk(fop.busy, 16'h0);
	endtask : t_wrong
	task t_early;
		wreg(REG_STORE_CTRL, 8'h01);
		xmove(1'b1, 1'b0, 1'b0, 16'h1100, 8'h00);
		chk(fop.busy, 16'h0);
		rreg(REG_UNLOCK_KEY);
		chk(d, 16'h2);
		unlock;
		xmove(1'b1, 1'b0, 1'b0, 16'h1100, 8'h00);
		chk(fop.busy, 16'h0);
	endtask : t_early

	initial begin
		{rst_n, reg_wr, reg_rd, fetch} = '0;
		por = 1'b1;
		{reg_addr, reg_wdata, fetch_addr} = '0;
		xd = '0;
		do_reset;
		t_reset;
		t_prog;
		t_erase;
		t_external_ram_space;
		t_fetch;
		t_monitor;
		do_reset;
		t_reset;
		rreg(REG_RESET_CAUSE);
		chk(d[0], 16'h1);
		t_short;
		do_reset;
		t_wrong;
		do_reset;
		t_early;
		give_verdict;
	end

	initial begin
		#20000;
		fails++;
		give_verdict;
	end
endmodule : tb_flash_program_erase_control
`default_nettype wire
